/* File: core/irq_enable_pkg.sv */
// Purpose: Shared constants and carriers for the interrupt enable block
// Assumes: Register offsets are byte addresses inside the controller window
// Notes:   Reserved enable positions are not implemented and read as zero
package irq_enable_pkg;

  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned SYNC_DEPTH = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET_GROUP0   = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET_GROUP1   = 12'h104;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR_GROUP0 = 12'h180;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR_GROUP1 = 12'h184;

  // Implemented enable positions; the holes are the reserved bits
  localparam logic [DATA_W-1:0] GROUP0_IMPL_MASK = 32'hbfff_fffb;
  localparam logic [DATA_W-1:0] GROUP1_IMPL_MASK = 32'h0000_011f;

  localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RDATA_IDLE   = 32'h0000_0000;

  // Register access request from the core side
  typedef struct packed {
    logic              sel;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  // First group enable layout, msb first
  typedef struct packed {
    logic       en_mailbox;
    logic       rsvd30;
    logic       en_real_time_clock;
    logic       en_adc_threshold_error;
    logic       en_adc_sequence_b;
    logic       en_adc_sequence_a;
    logic [1:0] en_spi_port;
    logic [2:0] en_i2c_port;
    logic [3:0] en_usart_port;
    logic       en_state_config_timer;
    logic [4:0] en_counter_timer;
    logic       en_multi_rate_timer;
    logic       en_micro_tick;
    logic [3:0] en_pin_slice;
    logic       en_gpio_group0;
    logic       en_dma;
    logic       rsvd2;
    logic       en_brownout;
    logic       en_watchdog;
  } group0_enables_t;

  // Second group enable layout, msb first
  typedef struct packed {
    logic [22:0] rsvd31_9;
    logic        en_repetitive_timer;
    logic [2:0]  rsvd7_5;
    logic [3:0]  en_pin_slice_hi;
    logic        en_gpio_group1;
  } group1_enables_t;

endpackage : irq_enable_pkg

/* File: core/line_sync.sv */
// Purpose: Two-stage synchroniser for a bus of independent level lines
// Assumes: Each bit is a level; no multi-bit coherence is implied
// Notes:   The first stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none

module line_sync #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : line_sync

`default_nettype wire

/* File: core/interrupt_enable_set_clear.sv */
// Purpose: Interrupt enable state with set-enable and clear-enable registers
// Assumes: One register access per request; peripheral lines are asynchronous
// Notes:   Enable state gates each line before it is passed to the core
// Function
// - First set register covers lines 0..31
// - Set register: ones enable, zeros ignored
// - Reads return current enable state
// - Group0 bits 0..8 gate listed sources
// - Group0 bits 9..16 gate timer sources
// - Group0 bits 17..25 gate serial ports
// - Group0 bits 26..31 gate ADC, clock, mailbox
// - Group0 bits 2, 30 reserved
// - Group1 bits 0..4, 8 gate listed sources
// - Group1 bits 7:5, 31:9 reserved
// - Clear register: ones disable, zeros ignored
// - Group0 clear shares mapping and flops
// - Group1 clear mirrors group1 set mapping
`timescale 1ns/1ps
`default_nettype none

module interrupt_enable_set_clear (
  input  wire logic                               ref_clk,
  input  wire logic                               reset,
  input  wire irq_enable_pkg::reg_req_t           reg_req,
  output var  logic [irq_enable_pkg::DATA_W-1:0]  reg_rdata,
  output var  logic                               reg_ready,
  output var  logic                               reg_error,
  input  wire logic [irq_enable_pkg::DATA_W-1:0]  line_in_group0,
  input  wire logic [irq_enable_pkg::DATA_W-1:0]  line_in_group1,
  output var  logic [irq_enable_pkg::DATA_W-1:0]  core_irq_group0,
  output var  logic [irq_enable_pkg::DATA_W-1:0]  core_irq_group1,
  output var  logic                               core_irq_any
);
  import irq_enable_pkg::*;

  group0_enables_t   enable0_reg;
  group0_enables_t   enable0_next;
  group1_enables_t   enable1_reg;
  group1_enables_t   enable1_next;
  logic [DATA_W-1:0] rdata_next;
  group0_enables_t   line0_view;
  group1_enables_t   line1_view;
  logic [DATA_W-1:0] gated_group0;
  logic [DATA_W-1:0] gated_group1;

  // Nets, since every source's synchroniser drives its own field
  wire group0_enables_t sync0_view;
  wire group1_enables_t sync1_view;

  // Address decode
  wire hit_set0   = (reg_req.addr == OFS_ENABLE_SET_GROUP0);
  wire hit_set1   = (reg_req.addr == OFS_ENABLE_SET_GROUP1);
  wire hit_clear0 = (reg_req.addr == OFS_ENABLE_CLEAR_GROUP0);
  wire hit_clear1 = (reg_req.addr == OFS_ENABLE_CLEAR_GROUP1);
  wire hit_group0 = hit_set0 | hit_clear0;
  wire hit_group1 = hit_set1 | hit_clear1;
  wire hit_any    = hit_group0 | hit_group1;

  wire wr_set0   = reg_req.sel & reg_req.write & hit_set0;
  wire wr_set1   = reg_req.sel & reg_req.write & hit_set1;
  wire wr_clear0 = reg_req.sel & reg_req.write & hit_clear0;
  wire wr_clear1 = reg_req.sel & reg_req.write & hit_clear1;
  wire rd_group0 = reg_req.sel & ~reg_req.write & hit_group0;
  wire rd_group1 = reg_req.sel & ~reg_req.write & hit_group1;

  // Writes into reserved positions are dropped so those bits never hold state
  wire [DATA_W-1:0] set_bits0   = reg_req.wdata & GROUP0_IMPL_MASK;
  wire [DATA_W-1:0] clear_bits0 = reg_req.wdata & GROUP0_IMPL_MASK;
  wire [DATA_W-1:0] set_bits1   = reg_req.wdata & GROUP1_IMPL_MASK;
  wire [DATA_W-1:0] clear_bits1 = reg_req.wdata & GROUP1_IMPL_MASK;

  // One request per cycle, so a set and a clear never meet in one edge
  assign enable0_next = wr_set0   ? (enable0_reg | set_bits0) :
                        wr_clear0 ? (enable0_reg & ~clear_bits0) :
                        enable0_reg;
  assign enable1_next = wr_set1   ? (enable1_reg | set_bits1) :
                        wr_clear1 ? (enable1_reg & ~clear_bits1) :
                        enable1_reg;

  // Set and clear addresses of one group read the same flops
  assign rdata_next = rd_group0 ? enable0_reg :
                      rd_group1 ? enable1_reg :
                      RDATA_IDLE;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enable0_reg <= ENABLE_RESET;
      enable1_reg <= ENABLE_RESET;
    end else begin
      enable0_reg <= enable0_next;
      enable1_reg <= enable1_next;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= RDATA_IDLE;
      reg_ready <= 1'b0;
      reg_error <= 1'b0;
    end else begin
      reg_rdata <= rdata_next;
      reg_ready <= reg_req.sel;
      reg_error <= reg_req.sel & ~hit_any;
    end
  end

  // Peripheral lines may come from other clocks. Each source has its own synchroniser
  // sized from its field, so a slip in the bit mapping shows up as a width clash
  assign line0_view = line_in_group0;
  assign line1_view = line_in_group1;

  line_sync #(
    .WIDTH    ($bits(line0_view.en_watchdog))
  ) u_sync_watchdog (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_watchdog),
    .sync_out (sync0_view.en_watchdog)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_brownout))
  ) u_sync_brownout (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_brownout),
    .sync_out (sync0_view.en_brownout)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_dma))
  ) u_sync_dma (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_dma),
    .sync_out (sync0_view.en_dma)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_gpio_group0))
  ) u_sync_gpio_group0 (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_gpio_group0),
    .sync_out (sync0_view.en_gpio_group0)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_pin_slice))
  ) u_sync_pin_slice (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_pin_slice),
    .sync_out (sync0_view.en_pin_slice)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_micro_tick))
  ) u_sync_micro_tick (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_micro_tick),
    .sync_out (sync0_view.en_micro_tick)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_multi_rate_timer))
  ) u_sync_multi_rate_timer (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_multi_rate_timer),
    .sync_out (sync0_view.en_multi_rate_timer)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_counter_timer))
  ) u_sync_counter_timer (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_counter_timer),
    .sync_out (sync0_view.en_counter_timer)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_state_config_timer))
  ) u_sync_state_config_timer (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_state_config_timer),
    .sync_out (sync0_view.en_state_config_timer)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_usart_port))
  ) u_sync_usart_port (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_usart_port),
    .sync_out (sync0_view.en_usart_port)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_i2c_port))
  ) u_sync_i2c_port (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_i2c_port),
    .sync_out (sync0_view.en_i2c_port)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_spi_port))
  ) u_sync_spi_port (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_spi_port),
    .sync_out (sync0_view.en_spi_port)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_adc_sequence_a))
  ) u_sync_adc_sequence_a (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_adc_sequence_a),
    .sync_out (sync0_view.en_adc_sequence_a)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_adc_sequence_b))
  ) u_sync_adc_sequence_b (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_adc_sequence_b),
    .sync_out (sync0_view.en_adc_sequence_b)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_adc_threshold_error))
  ) u_sync_adc_threshold_error (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_adc_threshold_error),
    .sync_out (sync0_view.en_adc_threshold_error)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_real_time_clock))
  ) u_sync_real_time_clock (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_real_time_clock),
    .sync_out (sync0_view.en_real_time_clock)
  );

  line_sync #(
    .WIDTH    ($bits(line0_view.en_mailbox))
  ) u_sync_mailbox (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line0_view.en_mailbox),
    .sync_out (sync0_view.en_mailbox)
  );

  line_sync #(
    .WIDTH    ($bits(line1_view.en_gpio_group1))
  ) u_sync_gpio_group1 (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line1_view.en_gpio_group1),
    .sync_out (sync1_view.en_gpio_group1)
  );

  line_sync #(
    .WIDTH    ($bits(line1_view.en_pin_slice_hi))
  ) u_sync_pin_slice_hi (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line1_view.en_pin_slice_hi),
    .sync_out (sync1_view.en_pin_slice_hi)
  );

  line_sync #(
    .WIDTH    ($bits(line1_view.en_repetitive_timer))
  ) u_sync_repetitive_timer (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (line1_view.en_repetitive_timer),
    .sync_out (sync1_view.en_repetitive_timer)
  );

  // Reserved positions have no source behind them
  assign sync0_view.rsvd2    = 1'b0;
  assign sync0_view.rsvd30   = 1'b0;
  assign sync1_view.rsvd7_5  = '0;
  assign sync1_view.rsvd31_9 = '0;

  // Bit n of each enable gates line n; the struct layout fixes the sources
  assign gated_group0 = sync0_view & enable0_reg;
  assign gated_group1 = sync1_view & enable1_reg;

  // Registered outputs add one cycle after the synchroniser
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      core_irq_group0 <= '0;
      core_irq_group1 <= '0;
      core_irq_any    <= 1'b0;
    end else begin
      core_irq_group0 <= gated_group0;
      core_irq_group1 <= gated_group1;
      core_irq_any    <= (|gated_group0) | (|gated_group1);
    end
  end

endmodule : interrupt_enable_set_clear

`default_nettype wire

/* File: test/irq_enable_checker.sv */
// Purpose: Port assertions for the interrupt enable block
// Assumes: Answer lands one cycle after the request edge
// Notes:   Reserved enable positions must read zero
`timescale 1ns/1ps
`default_nettype none
module irq_enable_checker
  import irq_enable_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire reg_req_t          reg_req,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_ready,
  input wire logic              reg_error,
  input wire logic [DATA_W-1:0] line_in_group0,
  input wire logic [DATA_W-1:0] line_in_group1,
  input wire logic [DATA_W-1:0] core_irq_group0,
  input wire logic [DATA_W-1:0] core_irq_group1,
  input wire logic              core_irq_any
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire rd = reg_req.sel && !reg_req.write;
  wire wr = reg_req.sel && reg_req.write;
  wire g0 = reg_req.addr inside {OFS_ENABLE_SET_GROUP0, OFS_ENABLE_CLEAR_GROUP0};
  wire g1 = reg_req.addr inside {OFS_ENABLE_SET_GROUP1, OFS_ENABLE_CLEAR_GROUP1};
  ack_on_hit_a: assert property (reg_req.sel && (g0 || g1) |=> reg_ready && !reg_error)
    else $error("mapped request not answered cleanly");
  error_on_miss_a: assert property (reg_req.sel && !g0 && !g1 |=> reg_ready && reg_error)
    else $error("unmapped request not flagged");
  quiet_idle_a: assert property (!reg_req.sel |=> !reg_ready && !reg_error)
    else $error("answer without request");
  idle_rdata_a: assert property (!rd |=> reg_rdata == '0)
    else $error("read data outside a read");
  rsvd_group0_a: assert property (rd && g0 |=> (reg_rdata & ~GROUP0_IMPL_MASK) == '0)
    else $error("group0 reserved bit reads one");
  rsvd_group1_a: assert property (rd && g1 |=> (reg_rdata & ~GROUP1_IMPL_MASK) == '0)
    else $error("group1 reserved bit reads one");
  set_read_back_a: assert property (wr && reg_req.addr == OFS_ENABLE_SET_GROUP0
    ##1 rd && g0 |=> (reg_rdata & $past(reg_req.wdata, 2) & GROUP0_IMPL_MASK)
        == ($past(reg_req.wdata, 2) & GROUP0_IMPL_MASK)) else $error("set bit not read back");
  clear_all_a: assert property (wr && reg_req.addr == OFS_ENABLE_CLEAR_GROUP0
    && (reg_req.wdata & GROUP0_IMPL_MASK) == GROUP0_IMPL_MASK ##1 rd && g0
    |=> reg_rdata == '0) else $error("clear left an enable set");
  gate_by_line_a: assert property (({core_irq_group1, core_irq_group0}
    & ~$past({line_in_group1, line_in_group0}, 3)) == '0) else $error("irq without line");
  any_matches_a: assert property (core_irq_any == |{core_irq_group1, core_irq_group0})
    else $error("summary irq disagrees");
  cover property (wr && g1 ##1 rd && g1);
  cover property (reg_error);
  cover property (core_irq_any);
endmodule : irq_enable_checker
bind interrupt_enable_set_clear irq_enable_checker u_chk (.ref_clk, .reset, .reg_req,
  .reg_rdata, .reg_ready, .reg_error, .line_in_group0, .line_in_group1,
  .core_irq_group0, .core_irq_group1, .core_irq_any);
`default_nettype wire

/* File: test/irq_line_source.sv */
// Purpose: Peripheral request lines feeding the block
// Assumes: Peripherals are not timed by the core clock
// Notes:   Levels land 7 ns after they are set, off the edge
`timescale 1ns/1ps
`default_nettype none
module irq_line_source (
  input  wire logic [31:0] level0,
  input  wire logic [31:0] level1,
  output wire logic [31:0] line0,
  output wire logic [31:0] line1
);
  assign #7 line0 = level0;
  assign #7 line1 = level1;
endmodule : irq_line_source
`default_nettype wire

/* File: test/interrupt_enable_set_clear_test.sv */
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: Bench plays the core and writes reserved bits as zero
// Notes:   Enable model is two integers beside the design
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_set_clear_test;
  import irq_enable_pkg::*;
  logic        ref_clk = 0;
  logic        reset = 1;
  reg_req_t    reg_req = '0;
  logic [31:0] reg_rdata, core_irq_group0, core_irq_group1, line_in_group0, line_in_group1;
  logic [31:0] lvl0 = '0;
  logic [31:0] lvl1 = '0;
  logic        reg_ready, reg_error, core_irq_any;
  int          bad_count = 0;
  int          checks_done = 0;
  int unsigned en[2] = '{0, 0};
  int unsigned seed = 9;
  logic [11:0] ofs[4] = '{OFS_ENABLE_SET_GROUP0, OFS_ENABLE_SET_GROUP1,
                          OFS_ENABLE_CLEAR_GROUP0, OFS_ENABLE_CLEAR_GROUP1};
  logic [31:0] msk[2] = '{GROUP0_IMPL_MASK, GROUP1_IMPL_MASK};
  interrupt_enable_set_clear u_dut (.ref_clk, .reset, .reg_req, .reg_rdata, .reg_ready,
    .reg_error, .line_in_group0, .line_in_group1, .core_irq_group0, .core_irq_group1,
    .core_irq_any);
  irq_line_source u_src (.level0(lvl0), .level1(lvl1), .line0(line_in_group0),
    .line1(line_in_group1));
  initial forever #10 ref_clk = ~ref_clk;
  function automatic int unsigned lfsr(int unsigned x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Slot k: bit 0 picks the group, bit 1 picks clear over set
  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    logic [31:0] exp;
    i = -1;
    foreach (ofs[k]) if (ofs[k] == a) i = k;
    exp = (i < 0 || wr) ? 32'h0 : en[i % 2];
    reg_req = '{1'b1, wr, a, d};
    @(posedge ref_clk);
    if (wr && i >= 0) en[i % 2] = i < 2 ? en[i % 2] | (d & msk[i % 2]) : en[i % 2] & ~d;
    #1;
    chk({30'h0, reg_ready, reg_error}, {30'h0, 1'b1, i < 0});
    chk(reg_rdata, exp);
  endtask : acc
  task automatic idle(input int n);
    reg_req.sel = 0;
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle
  task automatic lines(input logic [31:0] l0, input logic [31:0] l1);
    lvl0 = l0;
    lvl1 = l1;
    idle(4);
    chk(core_irq_group0, l0 & en[0]);
    chk(core_irq_group1, l1 & en[1]);
    chk({31'h0, core_irq_any}, {31'h0, |((l0 & en[0]) | (l1 & en[1]))});
  endtask : lines
  task automatic end_sim();
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (6) @(posedge ref_clk);
    #1;
    reset = 0;
    foreach (ofs[k]) acc(0, ofs[k], 0);
    for (int g = 0; g < 2; g++) begin
      for (int b = 0; b < 32; b++) begin
        acc(1, ofs[g], msk[g] & (32'h1 << b));
        acc(0, ofs[g + 2], 0);
        lines(32'hffff_ffff, 32'hffff_ffff);
        acc(1, ofs[g + 2], msk[g]);
        acc(0, ofs[g], 0);
      end
    end
    repeat (300) begin
      seed = lfsr(seed);
      acc(seed[0], ofs[seed[2:1]], seed & msk[seed[1]]);
      if (seed[3]) lines(seed, ~seed);
    end
    acc(1, 12'h200, 32'hffff_ffff);
    acc(0, 12'h108, 0);
    acc(0, ofs[0], 0);
    // Reset in mid-run with every enable set, so clearing them is really seen
    acc(1, ofs[0], msk[0]);
    acc(1, ofs[1], msk[1]);
    idle(1);
    reset = 1;
    en = '{0, 0};
    idle(2);
    reset = 0;
    foreach (ofs[k]) acc(0, ofs[k], 0);
    lines(32'hffff_ffff, 32'hffff_ffff);
    idle(1);
    end_sim();
  end
  initial begin
    // Run needs under 2,050 cycles; about five times that means a hang
    #200000;
    bad_count++;
    end_sim();
  end
endmodule : interrupt_enable_set_clear_test
`default_nettype wire
